// [wdt_regs.vh]
// register offsets, field positions, reset values and timing counts of the watchdog
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// special-function addresses
`define WDT_ADDR_UNLOCK 8'hc7
`define WDT_ADDR_CTRL 8'hd8

// watchdog_control field positions
`define WDT_BIT_RUN 7
`define WDT_BIT_ISEL_HI 5
`define WDT_BIT_ISEL_LO 4
`define WDT_BIT_TOF 3
`define WDT_BIT_RCF 2
`define WDT_BIT_RSTEN 1
`define WDT_BIT_RESTART 0

// watchdog_control reset value and its interval default
`define WDT_CTRL_RESET 8'h00
`define WDT_ISEL_RESET 2'h0

// config_word_zero clock source bit, zero picks the rc clock
`define WDT_CFG0_CLKSRC_BIT 7

// unlock keys
`define WDT_KEY_FIRST 8'haa
`define WDT_KEY_SECOND 8'h55

// time-out lengths in watchdog clocks per interval selection
`define WDT_TO_SEL0 16'h0040
`define WDT_TO_SEL1 16'h0200
`define WDT_TO_SEL2 16'h2000
`define WDT_TO_SEL3 16'h8000

// grace period after a time-out, in watchdog clocks
`define WDT_POST_TO_CLKS 10'h200

// timing in machine cycles
`define WDT_TA_WAIT_MC 3
`define WDT_TA_OPEN_MC 3
`define WDT_RST_HOLD_MC 2

`endif

// [wdt_unlock.v]
// timed-access unlock sequencer that opens the protected write window
`timescale 1ns/1ns
`include "wdt_regs.vh"

module wdt_unlock #(
  parameter MC_CLKS = 12
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // unlock register write
  input wire key_wr,
  input wire [7:0] key_data,
  // window state
  output wire win_open
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_WAIT = 3'b010;
  localparam [2:0] ST_OPEN = 3'b100;
  // timers are 8 bits wide, so MC_CLKS must stay below 86
  localparam [31:0] WAIT_FULL = `WDT_TA_WAIT_MC * MC_CLKS;
  localparam [31:0] OPEN_FULL = `WDT_TA_OPEN_MC * MC_CLKS;
  localparam [7:0] WAIT_CLKS = WAIT_FULL[7:0];
  localparam [7:0] OPEN_CLKS = OPEN_FULL[7:0];

  reg [2:0] state_ff;
  reg [2:0] nxt_state;
  reg [7:0] timer_ff;
  reg [7:0] nxt_timer;

  always @* begin
    nxt_state = state_ff;
    nxt_timer = timer_ff;
    case (state_ff)
      ST_IDLE: begin
        if (key_wr && key_data == `WDT_KEY_FIRST) begin
          nxt_state = ST_WAIT;
          nxt_timer = WAIT_CLKS;
        end
      end
      ST_WAIT: begin
        if (key_wr && key_data == `WDT_KEY_SECOND) begin
          nxt_state = ST_OPEN;
          nxt_timer = OPEN_CLKS;
        end else if (key_wr && key_data == `WDT_KEY_FIRST) begin
          nxt_timer = WAIT_CLKS;
        end else if (key_wr || timer_ff == 8'h01) begin
          // a late or wrong key leaves the window shut
          nxt_state = ST_IDLE;
        end else begin
          nxt_timer = timer_ff - 8'h01;
        end
      end
      ST_OPEN: begin
        // keys written while open are ignored, the window is not stretched
        if (timer_ff == 8'h01) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_timer = timer_ff - 8'h01;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
        nxt_timer = 8'h00;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!nrst) begin
      state_ff <= ST_IDLE;
      timer_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
    end
  end

  assign win_open = state_ff[2];

endmodule // wdt_unlock

// [wdt_top.v]
// watchdog timer with timed-access protected control register
//
// Summary of operation
// - writing one to restart strobe clears counter; hardware then clears the strobe
// - interval select picks 64, 512, 8192 or 32768 watchdog clocks
// - reaching the selected time-out sets the time-out flag, control bit 3
// - interrupt request only when flag, watchdog enable and global enable all set
// - after time-out wait 512 clocks; with reset enabled and no restart, reset
// - watchdog reset lasts two machine cycles and sets reset cause flag, bit 2
// - reset enable clear suppresses reset, counter keeps running; set enables it
// - reset cause flag cleared only by software, power-on or power-fail reset; untouched if disabled
// - time-out flag cleared by software write and by every reset
// - power-on/fail reset disables watchdog; watchdog reset keeps it running, restarted
// - after reset interval selection defaults to 64 clocks
// - protected control bits change only while the timed window is open
// - run bit, control bit 7, lets the counter advance
// - config word bit 7 picks rc clock or cpu clock for the watchdog
// - on rc clock, restart strobe clears only once the counter is non-zero
// - window opens only on AAh then 55h within 3 machine cycles
// - window open 3 machine cycles then closes; closed-window writes discarded except a clear of the cause flag, bit 2
// - unlock register sits at special-function address C7h
// - with interrupt and reset off, counter keeps running, flag set each interval
`timescale 1ns/1ns
`include "wdt_regs.vh"

module wdt_top #(
  parameter MC_CLKS = 12
) (
  // clock and power-on reset
  input wire clk,
  input wire nrst,
  // power-fail reset, same clock domain
  input wire pwr_fail_rst,
  // special-function register port
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire [7:0] sfr_wdata,
  output wire [7:0] sfr_rdata,
  // configuration and clock source
  input wire [7:0] config_word_zero,
  input wire rc_clk_in,
  // interrupt enables held elsewhere
  input wire wdog_irq_enable,
  input wire global_irq_enable,
  // requests to the system
  output wire wdog_irq,
  output wire wdog_sys_rst
);

  // stretch counter is 8 bits, enough for any sane machine cycle length
  localparam [31:0] HOLD_FULL = `WDT_RST_HOLD_MC * MC_CLKS;
  localparam [7:0] HOLD_CLKS = HOLD_FULL[7:0];
  localparam [7:0] CTRL_RST = `WDT_CTRL_RESET;

  // interval select to terminal count
  function [15:0] wdt_term;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: wdt_term = `WDT_TO_SEL0;
        2'h1: wdt_term = `WDT_TO_SEL1;
        2'h2: wdt_term = `WDT_TO_SEL2;
        default: wdt_term = `WDT_TO_SEL3;
      endcase
    end
  endfunction

  // control register decode, shared by the write and read paths
  function addr_is_ctrl;
    input [7:0] addr;
    begin
      addr_is_ctrl = addr == `WDT_ADDR_CTRL;
    end
  endfunction

  // rc clock synchroniser
  reg rc_s1_ff;
  reg rc_s2_ff;
  reg rc_s3_ff;

  // control bits
  reg run_ff;
  reg [1:0] isel_ff;
  reg tof_ff;
  reg rcf_ff;
  reg rsten_ff;
  reg restart_ff;

  // counting state
  reg [15:0] cnt_ff;
  reg [9:0] post_ff;
  reg post_act_ff;
  reg [7:0] hold_ff;
  reg [7:0] nxt_hold;

  // outputs
  reg [7:0] rdata_ff;
  reg irq_ff;
  reg sys_rst_ff;

  wire hard_rst;
  wire hold_act;
  wire seq_rst_n;
  wire use_rc;
  wire rc_tick;
  wire wdt_tick;
  wire wr_ctrl;
  wire wr_key;
  wire win_open;
  wire prot_wr;
  wire restart_wr;
  wire at_term;
  wire timeout_evt;
  wire post_done;
  wire fire;
  wire [7:0] ctrl_value;

  // power-on and power-fail are the hard resets, the watchdog one is softer
  assign hard_rst = !nrst || pwr_fail_rst;
  assign hold_act = hold_ff != 8'h00;
  assign seq_rst_n = !(hard_rst || hold_act);

  // zero in the config bit picks the slow rc clock
  assign use_rc = !config_word_zero[`WDT_CFG0_CLKSRC_BIT];

  // rising edge counted when the second stage has it and the third does not yet
  assign rc_tick = rc_s2_ff && !rc_s3_ff;
  assign wdt_tick = use_rc ? rc_tick : 1'b1;

  always @(posedge clk) begin
    if (!nrst) begin
      rc_s1_ff <= 1'b0;
      rc_s2_ff <= 1'b0;
      rc_s3_ff <= 1'b0;
    end else begin
      rc_s1_ff <= rc_clk_in;
      rc_s2_ff <= rc_s1_ff;
      rc_s3_ff <= rc_s2_ff;
    end
  end

  // register decode
  assign wr_key = sfr_wr && sfr_addr == `WDT_ADDR_UNLOCK;
  assign wr_ctrl = sfr_wr && addr_is_ctrl(sfr_addr);
  assign prot_wr = wr_ctrl && win_open;
  assign restart_wr = prot_wr && sfr_wdata[`WDT_BIT_RESTART];

  wdt_unlock #(
    .MC_CLKS(MC_CLKS)
  ) u_unlock (
    .clk(clk),
    .nrst(seq_rst_n),
    .key_wr(wr_key),
    .key_data(sfr_wdata),
    .win_open(win_open)
  );

  // time-out detection
  assign at_term = cnt_ff == wdt_term(isel_ff) - 16'h0001;
  assign timeout_evt = run_ff && wdt_tick && at_term && !restart_wr;

  // grace period end, reset only if enabled and no restart arrived
  assign post_done = post_act_ff && wdt_tick && post_ff == `WDT_POST_TO_CLKS - 10'h001;
  assign fire = post_done && rsten_ff && !restart_wr && !hold_act;

  // watchdog counter, free running over the selected interval
  always @(posedge clk) begin
    if (hard_rst || hold_act) begin
      cnt_ff <= 16'h0000;
    end else if (restart_wr) begin
      cnt_ff <= 16'h0000;
    end else if (run_ff && wdt_tick) begin
      if (at_term) begin
        cnt_ff <= 16'h0000;
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end

  // grace counter after a time-out
  always @(posedge clk) begin
    if (hard_rst || hold_act || restart_wr) begin
      post_act_ff <= 1'b0;
      post_ff <= 10'h000;
    end else if (timeout_evt && !post_act_ff) begin
      post_act_ff <= 1'b1;
      post_ff <= 10'h000;
    end else if (post_act_ff && wdt_tick) begin
      if (post_done) begin
        post_act_ff <= 1'b0;
        post_ff <= 10'h000;
      end else begin
        post_ff <= post_ff + 10'h001;
      end
    end
  end

  // watchdog reset stretch
  always @* begin
    if (fire) begin
      nxt_hold = HOLD_CLKS;
    end else if (hold_act) begin
      nxt_hold = hold_ff - 8'h01;
    end else begin
      nxt_hold = 8'h00;
    end
  end

  always @(posedge clk) begin
    if (hard_rst) begin
      hold_ff <= 8'h00;
      sys_rst_ff <= 1'b0;
    end else begin
      hold_ff <= nxt_hold;
      sys_rst_ff <= nxt_hold != 8'h00;
    end
  end

  // run bit survives a watchdog reset so the watchdog restarts itself
  always @(posedge clk) begin
    if (hard_rst) begin
      run_ff <= CTRL_RST[`WDT_BIT_RUN];
    end else if (prot_wr && !hold_act) begin
      run_ff <= sfr_wdata[`WDT_BIT_RUN];
    end
  end

  always @(posedge clk) begin
    if (hard_rst || hold_act) begin
      isel_ff <= `WDT_ISEL_RESET;
    end else if (prot_wr) begin
      isel_ff <= sfr_wdata[`WDT_BIT_ISEL_HI:`WDT_BIT_ISEL_LO];
    end
  end

  // reset enable kept across a watchdog reset
  always @(posedge clk) begin
    if (hard_rst) begin
      rsten_ff <= 1'b0;
    end else if (prot_wr && !hold_act) begin
      rsten_ff <= sfr_wdata[`WDT_BIT_RSTEN];
    end
  end

  // hardware set wins over a software clear in the same cycle
  always @(posedge clk) begin
    if (hard_rst || hold_act) begin
      tof_ff <= 1'b0;
    end else if (timeout_evt) begin
      tof_ff <= 1'b1;
    end else if (prot_wr) begin
      tof_ff <= sfr_wdata[`WDT_BIT_TOF];
    end
  end

  // cause flag is not protected; software may only clear it
  always @(posedge clk) begin
    if (hard_rst) begin
      rcf_ff <= 1'b0;
    end else if (fire) begin
      rcf_ff <= 1'b1;
    end else if (wr_ctrl && !sfr_wdata[`WDT_BIT_RCF]) begin
      rcf_ff <= 1'b0;
    end
  end

  // on the rc clock the strobe lingers until the slow counter moves;
  // stopping the rc clock before then leaves it stuck
  always @(posedge clk) begin
    if (hard_rst || hold_act) begin
      restart_ff <= 1'b0;
    end else if (restart_wr) begin
      restart_ff <= 1'b1;
    end else if (restart_ff && (!use_rc || cnt_ff != 16'h0000)) begin
      restart_ff <= 1'b0;
    end
  end

  assign ctrl_value = {run_ff, 1'b0, isel_ff, tof_ff, rcf_ff, rsten_ff, restart_ff};

  // read data registered; unlock register is write only
  always @(posedge clk) begin
    if (hard_rst) begin
      rdata_ff <= 8'h00;
    end else if (addr_is_ctrl(sfr_addr)) begin
      rdata_ff <= ctrl_value;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  always @(posedge clk) begin
    if (hard_rst || hold_act) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= tof_ff && wdog_irq_enable && global_irq_enable;
    end
  end

  assign sfr_rdata = rdata_ff;
  assign wdog_irq = irq_ff;
  assign wdog_sys_rst = sys_rst_ff;

endmodule // wdt_top

// [wdt_top_assertions.sv]
// port checker for the watchdog top
`timescale 1ns/1ns
module wdt_top_chk #(
  parameter MC_CLKS = 12
) (
  // clock and resets
  input wire clk,
  input wire nrst,
  input wire pwr_fail_rst,
  // register port
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_rdata,
  // interrupt and reset side
  input wire wdog_irq_enable,
  input wire global_irq_enable,
  input wire wdog_irq,
  input wire wdog_sys_rst
);
  reg [4:0] len_ff;
  reg [9:0] gap_ff;
  // gap saturates, only a lower bound matters
  always @(posedge clk) begin
    len_ff <= wdog_sys_rst ? len_ff + 5'h1 : 5'h0;
    if (!nrst || pwr_fail_rst || wdog_sys_rst)
      gap_ff <= 10'h0;
    else if (gap_ff != 10'h3ff)
      gap_ff <= gap_ff + 10'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_rd_unlock;
    sfr_addr == 8'hc7 |=> sfr_rdata == 8'h00;
  endproperty
  a_rd_unlock: assert property (p_rd_unlock) else $error("unlock reads nonzero");
  property p_rst_len;
    $fell(wdog_sys_rst) |-> len_ff == 2 * MC_CLKS;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");
  property p_rst_max;
    len_ff <= 2 * MC_CLKS;
  endproperty
  a_rst_max: assert property (p_rst_max) else $error("reset pulse too long");
  property p_after_por;
    $rose(nrst) |-> !wdog_sys_rst && !wdog_irq && sfr_rdata == 8'h00;
  endproperty
  a_after_por: assert property (p_after_por) else $error("outputs not idle");
  property p_pwrfail;
    pwr_fail_rst |=> !wdog_sys_rst && !wdog_irq;
  endproperty
  a_pwrfail: assert property (p_pwrfail) else $error("power-fail left output");
  property p_irq_drop;
    !(wdog_irq_enable && global_irq_enable) |=> !wdog_irq;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("irq without enables");
  property p_irq_cause;
    $rose(wdog_irq) |-> $past(wdog_irq_enable) && $past(global_irq_enable);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose unenabled");
  property p_rst_gap;
    $rose(wdog_sys_rst) |-> gap_ff >= 10'h23c;
  endproperty
  a_rst_gap: assert property (p_rst_gap) else $error("reset came too early");
  property p_rst_irq;
    $rose(wdog_sys_rst) |-> ##3 !wdog_irq;
  endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("flag kept over reset");
endmodule // wdt_top_chk

// [tb.sv]
// self-checking bench for the watchdog top
`timescale 1ns/1ns
`include "wdt_regs.vh"
module tb;
  localparam MC = 4;
  reg clk, nrst, pwr_fail_rst, sfr_wr, rc_clk_in, rc_on;
  reg wdog_irq_enable, global_irq_enable;
  reg [7:0] sfr_addr, sfr_wdata, config_word_zero;
  wire [7:0] sfr_rdata;
  wire wdog_irq, wdog_sys_rst;
  wire [8:0] obs = {wdog_sys_rst, sfr_rdata};
  integer fail_count, cmp_count, n, i, term;
  reg [1:0] rc_div;
  wdt_top #(.MC_CLKS(MC)) u_wdt_top (.clk(clk), .nrst(nrst), .pwr_fail_rst(pwr_fail_rst),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .config_word_zero(config_word_zero), .rc_clk_in(rc_clk_in),
    .wdog_irq_enable(wdog_irq_enable), .global_irq_enable(global_irq_enable),
    .wdog_irq(wdog_irq), .wdog_sys_rst(wdog_sys_rst));
  always #50 clk = ~clk;
  // slow clock made on clk edges, one toggle every four cycles
  always @(posedge clk) begin
    rc_div <= rc_div + 2'h1;
    if (rc_on && rc_div == 2'h3)
      rc_clk_in <= ~rc_clk_in;
  end
  task conclude;
    begin
      if (fail_count == 0 && cmp_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_wr <= 1'b1;
      @(posedge clk);
      sfr_wr <= 1'b0;
      sfr_addr <= `WDT_ADDR_CTRL;
    end
  endtask
  // protected write, full unlock each time
  task pwr(input [7:0] d);
    begin
      wr(8'hc7, 8'haa);
      wr(8'hc7, 8'h55);
      wr(`WDT_ADDR_CTRL, d);
    end
  endtask
  task rd(input [7:0] exp);
    begin
      repeat (2) @(posedge clk);
      #1 chk(sfr_rdata, exp);
    end
  endtask
  task wait_bit(input integer idx, input v, input integer lim);
    begin
      n = 0;
      @(posedge clk);
      #1;
      while (obs[idx] !== v && n < lim) begin
        @(posedge clk);
        #1 n = n + 1;
      end
      if (n >= lim) begin
        fail_count = fail_count + 1;
        conclude;
      end
    end
  endtask
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    pwr_fail_rst = 1'b0;
    sfr_wr = 1'b0;
    rc_clk_in = 1'b0;
    rc_on = 1'b0;
    rc_div = 2'h0;
    wdog_irq_enable = 1'b0;
    global_irq_enable = 1'b0;
    sfr_addr = 8'hd8;
    sfr_wdata = 8'h00;
    config_word_zero = 8'h80;
    fail_count = 0;
    cmp_count = 0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rd(8'h00);
    wr(`WDT_ADDR_CTRL, 8'h81);
    rd(8'h00);
    wr(8'hc7, 8'haa);
    repeat (3 * MC + 2) @(posedge clk);
    wr(8'hc7, 8'h55);
    wr(`WDT_ADDR_CTRL, 8'h81);
    rd(8'h00);
    wr(8'hc7, 8'haa);
    wr(8'hc7, 8'h55);
    repeat (3 * MC) @(posedge clk);
    wr(`WDT_ADDR_CTRL, 8'h81);
    rd(8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      term = 64 << ((i == 0) ? 0 : (i == 1) ? 3 : (i == 2) ? 7 : 9);
      pwr(8'h81 | 8'(i << 4));
      wait_bit(3, 1'b1, term + 10);
      chk({7'h0, n >= term - 3 && n <= term + 3}, 8'h01);
      rd(8'h88 | 8'(i << 4));
    end
    // flag still set, now open the request path
    @(posedge clk);
    wdog_irq_enable <= 1'b1;
    global_irq_enable <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({7'h0, wdog_irq}, 8'h01);
    @(posedge clk);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk({7'h0, wdog_irq}, 8'h00);
    pwr(8'h81);
    rd(8'h80);
    // request path open so the reset must visibly drop the interrupt
    @(posedge clk);
    global_irq_enable <= 1'b1;
    pwr(8'h83);
    wait_bit(8, 1'b1, 700);
    n = 0;
    while (wdog_sys_rst && n < 50) begin
      @(posedge clk);
      #1 n = n + 1;
    end
    chk(n[7:0], 8'(`WDT_RST_HOLD_MC * MC));
    rd(8'h86);
    wr(`WDT_ADDR_CTRL, 8'h82);
    rd(8'h82);
    pwr(8'h00);
    rd(8'h00);
    pwr(8'h81);
    wait_bit(3, 1'b1, 80);
    repeat (600) @(posedge clk);
    rd(8'h88);
    @(posedge clk);
    pwr_fail_rst <= 1'b1;
    @(posedge clk);
    pwr_fail_rst <= 1'b0;
    rd(8'h00);
    // stopped slow clock: strobe must hang set
    @(posedge clk);
    config_word_zero <= 8'h00;
    pwr(8'h81);
    rd(8'h81);
    rc_on = 1'b1;
    wait_bit(0, 1'b0, 200);
    rc_on = 1'b0;
    rd(8'h80);
    conclude;
  end
endmodule // tb
bind wdt_top wdt_top_chk #(.MC_CLKS(MC_CLKS)) u_wdt_top_chk (.clk(clk), .nrst(nrst),
  .pwr_fail_rst(pwr_fail_rst), .sfr_addr(sfr_addr), .sfr_rdata(sfr_rdata),
  .wdog_irq_enable(wdog_irq_enable), .global_irq_enable(global_irq_enable),
  .wdog_irq(wdog_irq), .wdog_sys_rst(wdog_sys_rst));
